// File: rtl/cgps_pkg.sv
// Constants for the clock generator and power save controller.
// Assumes a 20 MHz system clock and a classic Wishbone register port.
package cgps_pkg;
  // Register byte offsets
  localparam logic [3:0] OFF_DIV = 4'h0;
  localparam logic [3:0] OFF_STAT = 4'h4;
  localparam logic [3:0] OFF_PWR = 4'h8;
  localparam logic [3:0] OFF_KEY = 4'hC;
  // Divider control fields
  localparam int DIV_LOW_BIT = 0;
  localparam int DIV_HIGH_BIT = 1;
  // Status fields
  localparam int STAT_LOCK_BIT = 0;
  localparam int STAT_ERR_BIT = 4;
  localparam int STAT_DIRECT_BIT = 7;
  // Power save control fields
  localparam int PWR_INHIBIT_BIT = 0;
  localparam int PWR_STOP_BIT = 1;
  localparam int PWR_IDLE_BIT = 2;
  localparam int PWR_EXT_BIT = 3;
  // Unlock key for the protected write, value arbitrary
  localparam logic [7:0] KEY_VALUE = 8'hA5;
  // Reset values
  localparam logic [1:0] DIV_RESET = 2'h0;
  // Timing
  localparam int CLK_MHZ = 20;
  localparam int LOCK_TIME_US = 150;
  localparam int OSC_STAB_US = 100;
  localparam int LOSS_TIME_NS = 2000;
  localparam int CLK_PERIOD_NS = 1000 / CLK_MHZ;
  localparam int LOCK_CYC = LOCK_TIME_US * CLK_MHZ;
  localparam int OSC_STAB_CYC = OSC_STAB_US * CLK_MHZ;
  localparam int LOSS_CYC = LOSS_TIME_NS / CLK_PERIOD_NS;
  localparam int CNT_W = 16;

  typedef enum logic [2:0] {
    CGPS_NORMAL = 3'b000,
    CGPS_HALT = 3'b001,
    CGPS_IDLE = 3'b010,
    CGPS_STOP = 3'b011,
    CGPS_STAB = 3'b100
  } cgps_state_t;

  // Ratio of system clock to input clock
  typedef enum logic [1:0] {
    CGPS_X5 = 2'b00,
    CGPS_X1 = 2'b01,
    CGPS_HALF = 2'b10,
    CGPS_FREE = 2'b11
  } cgps_ratio_t;
endpackage

// File: rtl/cgps_sync.sv
// Two flip-flop synchroniser for a group of pin inputs.
// Assumes the inputs are asynchronous levels; no reset so that a pin
// can be observed while the block is held in reset.
`timescale 1ns/1ps
`default_nettype none
module cgps_sync #(
  parameter int W = 1
) (
  input wire logic CLK_SYS,
  input wire logic [W-1:0] PIN_IN,
  output logic [W-1:0] PIN_OUT
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } cgps_sync_t;

  cgps_sync_t r_reg;
  cgps_sync_t r_next;

  always_comb begin
    r_next.s1 = PIN_IN;
    r_next.s2 = r_reg.s1;
  end

  always_ff @(posedge CLK_SYS) begin
    r_reg <= r_next;
  end

  assign PIN_OUT = r_reg.s2;
endmodule
`default_nettype wire

// File: rtl/cgps_top.sv
// Clock generator control and power save modes with a Wishbone slave.
// Assumes one 20 MHz clock; mode pin, clock-present, NMI and interrupt
// request arrive asynchronously and are synchronised here.
// Operation
// - Mode pin latched at reset; low is PLL mode, high is direct mode.
// - Direct mode gives a system clock of half the input clock.
// - PLL mode starts at five times the input clock after reset.
// - Lost input clock in PLL mode falls back to free-running VCO.
// - Divider register is 8 bits, written only through the protected sequence.
// - Divider 00 gives x5, 10 gives x1, 11 gives half; others prohibited.
// - Status register shows PLL lock and protection error flags.
// - HALT keeps oscillator, PLL and peripheral clock; CPU clock stops.
// - IDLE keeps oscillator and PLL, stops system clock, no wait on exit.
// - Software STOP stops oscillator and PLL and every internal clock.
// - After STOP in PLL mode, wait oscillation stabilisation before use.
// - Clock output inhibit keeps the system clock off the output pin.
// - External clock keeps oscillator off; direct mode runs neither.
// - Power save register is 8 bits, written only by protected sequence.
// - Idle and stop bits both set enter STOP, not IDLE.
// - Writing 1 to the stop request bit enters software STOP.
// - Stop request bit clears itself when STOP is released.
// - HALT ends on NMI, any unmasked interrupt, or reset.
// - IDLE ends only on NMI or reset.
`timescale 1ns/1ps
`default_nettype none
module cgps_top #(
  parameter int LOCK_CYCLES = cgps_pkg::LOCK_CYC,
  parameter int STAB_CYCLES = cgps_pkg::OSC_STAB_CYC,
  parameter int LOSS_CYCLES = cgps_pkg::LOSS_CYC
) (
  input wire logic CLK_SYS,
  input wire logic RST_B,
  input wire logic CLOCK_MODE_SELECT_PIN,
  input wire logic INPUT_CLK_PRESENT,
  input wire logic NMI_IN,
  input wire logic INT_REQ,
  input wire logic HALT_REQ,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [3:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  output logic OSC_EN,
  output logic PLL_EN,
  output logic CPU_CLK_EN,
  output logic PERI_CLK_EN,
  output logic SYSTEM_CLOCK_OUTPUT_EN,
  output logic [1:0] CLK_RATIO,
  output logic PLL_LOCK,
  output logic DIRECT_MODE
);
  typedef struct packed {
    logic direct;
    logic div_high;
    logic div_low;
    logic inhibit;
    logic idle_bit;
    logic stop_bit;
    logic ext_bit;
    logic armed;
    logic err;
    cgps_pkg::cgps_state_t state;
    logic lock;
    logic [cgps_pkg::CNT_W-1:0] lock_cnt;
    logic [cgps_pkg::CNT_W-1:0] stab_cnt;
    logic [cgps_pkg::CNT_W-1:0] loss_cnt;
    logic ack;
    logic [7:0] rdata;
    logic osc_en;
    logic pll_en;
    logic cpu_en;
    logic peri_en;
    logic clk_out_en;
    cgps_pkg::cgps_ratio_t ratio;
  } cgps_regs_t;

  localparam logic [cgps_pkg::CNT_W-1:0] LOCK_N =
    cgps_pkg::CNT_W'(LOCK_CYCLES);
  localparam logic [cgps_pkg::CNT_W-1:0] STAB_N =
    cgps_pkg::CNT_W'(STAB_CYCLES);
  localparam logic [cgps_pkg::CNT_W-1:0] LOSS_N =
    cgps_pkg::CNT_W'(LOSS_CYCLES);

  cgps_regs_t r_reg;
  cgps_regs_t r_next;
  logic [3:0] pins_s;
  logic mode_s;
  logic present_s;
  logic nmi_s;
  logic int_s;

  cgps_sync #(.W(4)) u_sync (
    .CLK_SYS(CLK_SYS),
    .PIN_IN({CLOCK_MODE_SELECT_PIN, INPUT_CLK_PRESENT, NMI_IN, INT_REQ}),
    .PIN_OUT(pins_s)
  );
  assign mode_s = pins_s[3];
  assign present_s = pins_s[2];
  assign nmi_s = pins_s[1];
  assign int_s = pins_s[0];

  logic req;
  logic wr;
  logic err_set;
  logic err_clr;
  logic relock;
  logic clk_ok;
  logic stop_ok;

  always_comb begin
    r_next = r_reg;
    req = CYC_I & STB_I & ~r_reg.ack;
    wr = req & WE_I & SEL_I[0];
    err_set = 1'b0;
    err_clr = 1'b0;
    relock = 1'b0;
    r_next.ack = req;

    // Protected writes: a key write arms exactly the next bus write
    if (wr) begin
      r_next.armed = 1'b0;
      case (ADR_I)
        cgps_pkg::OFF_KEY: begin
          r_next.armed = (DAT_I[7:0] == cgps_pkg::KEY_VALUE);
        end
        cgps_pkg::OFF_DIV: begin
          if (!r_reg.armed ||
              DAT_I[cgps_pkg::DIV_HIGH_BIT:cgps_pkg::DIV_LOW_BIT] == 2'h1) begin
            err_set = 1'b1;
          end else begin
            r_next.div_high = DAT_I[cgps_pkg::DIV_HIGH_BIT];
            r_next.div_low = DAT_I[cgps_pkg::DIV_LOW_BIT];
            relock = (DAT_I[cgps_pkg::DIV_HIGH_BIT] != r_reg.div_high) ||
                     (DAT_I[cgps_pkg::DIV_LOW_BIT] != r_reg.div_low);
          end
        end
        cgps_pkg::OFF_PWR: begin
          if (!r_reg.armed) begin
            err_set = 1'b1;
          end else begin
            r_next.inhibit = DAT_I[cgps_pkg::PWR_INHIBIT_BIT];
            r_next.stop_bit = DAT_I[cgps_pkg::PWR_STOP_BIT];
            r_next.idle_bit = DAT_I[cgps_pkg::PWR_IDLE_BIT];
            r_next.ext_bit = DAT_I[cgps_pkg::PWR_EXT_BIT];
          end
        end
        cgps_pkg::OFF_STAT: begin
          err_clr = DAT_I[cgps_pkg::STAT_ERR_BIT];
        end
        default: begin
        end
      endcase
    end
    // Set wins over a clear in the same cycle
    r_next.err = (r_reg.err & ~err_clr) | err_set;

    // Power save sequencing
    case (r_reg.state)
      cgps_pkg::CGPS_NORMAL: begin
        if (r_reg.stop_bit) begin
          r_next.state = cgps_pkg::CGPS_STOP;
        end else if (r_reg.idle_bit) begin
          r_next.state = cgps_pkg::CGPS_IDLE;
        end else if (HALT_REQ) begin
          r_next.state = cgps_pkg::CGPS_HALT;
        end
      end
      cgps_pkg::CGPS_HALT: begin
        if (nmi_s | int_s) begin
          r_next.state = cgps_pkg::CGPS_NORMAL;
        end
      end
      cgps_pkg::CGPS_IDLE: begin
        if (nmi_s) begin
          // No stabilisation wait: oscillator and PLL kept running
          r_next.state = cgps_pkg::CGPS_NORMAL;
          r_next.idle_bit = 1'b0;
        end
      end
      cgps_pkg::CGPS_STOP: begin
        if (nmi_s) begin
          r_next.stop_bit = 1'b0;
          r_next.idle_bit = 1'b0;
          r_next.stab_cnt = '0;
          r_next.state = r_reg.direct ? cgps_pkg::CGPS_NORMAL
                                      : cgps_pkg::CGPS_STAB;
        end
      end
      cgps_pkg::CGPS_STAB: begin
        r_next.stab_cnt = r_reg.stab_cnt + 1'b1;
        if (r_reg.stab_cnt >= STAB_N - 1'b1) begin
          r_next.state = cgps_pkg::CGPS_NORMAL;
        end
      end
      default: begin
        r_next.state = cgps_pkg::CGPS_NORMAL;
      end
    endcase

    // Input clock loss: no present level for LOSS_N cycles
    if (present_s) begin
      r_next.loss_cnt = '0;
    end else if (r_reg.loss_cnt < LOSS_N) begin
      r_next.loss_cnt = r_reg.loss_cnt + 1'b1;
    end
    clk_ok = (r_reg.loss_cnt < LOSS_N);
    stop_ok = (r_next.state != cgps_pkg::CGPS_STOP);

    // Clock tree enables
    r_next.osc_en = ~r_reg.direct & ~r_reg.ext_bit & stop_ok;
    r_next.pll_en = ~r_reg.direct & stop_ok;
    r_next.cpu_en = (r_next.state == cgps_pkg::CGPS_NORMAL);
    r_next.peri_en = (r_next.state == cgps_pkg::CGPS_NORMAL) ||
                     (r_next.state == cgps_pkg::CGPS_HALT);
    r_next.clk_out_en = r_next.peri_en & ~r_next.inhibit;

    // Ratio of the system clock to the input clock
    if (r_reg.direct) begin
      r_next.ratio = cgps_pkg::CGPS_HALF;
    end else if (!clk_ok) begin
      r_next.ratio = cgps_pkg::CGPS_FREE;
    end else if (!r_next.div_high) begin
      r_next.ratio = cgps_pkg::CGPS_X5;
    end else if (!r_next.div_low) begin
      r_next.ratio = cgps_pkg::CGPS_X1;
    end else begin
      r_next.ratio = cgps_pkg::CGPS_HALF;
    end

    // Lock restarts on any unlock cause
    if (!r_next.pll_en || !clk_ok || relock) begin
      r_next.lock_cnt = '0;
      r_next.lock = 1'b0;
    end else if (r_reg.lock_cnt >= LOCK_N - 1'b1) begin
      r_next.lock = 1'b1;
    end else begin
      r_next.lock_cnt = r_reg.lock_cnt + 1'b1;
    end

    // Read data, byte lane 0 only; unmapped reads return zero
    r_next.rdata = 8'h00;
    if (req && !WE_I) begin
      case (ADR_I)
        cgps_pkg::OFF_DIV: begin
          r_next.rdata[cgps_pkg::DIV_HIGH_BIT] = r_reg.div_high;
          r_next.rdata[cgps_pkg::DIV_LOW_BIT] = r_reg.div_low;
        end
        cgps_pkg::OFF_STAT: begin
          r_next.rdata[cgps_pkg::STAT_LOCK_BIT] = r_reg.lock;
          r_next.rdata[cgps_pkg::STAT_ERR_BIT] = r_reg.err;
          r_next.rdata[cgps_pkg::STAT_DIRECT_BIT] = r_reg.direct;
        end
        cgps_pkg::OFF_PWR: begin
          r_next.rdata[cgps_pkg::PWR_INHIBIT_BIT] = r_reg.inhibit;
          r_next.rdata[cgps_pkg::PWR_STOP_BIT] = r_reg.stop_bit;
          r_next.rdata[cgps_pkg::PWR_IDLE_BIT] = r_reg.idle_bit;
          r_next.rdata[cgps_pkg::PWR_EXT_BIT] = r_reg.ext_bit;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      r_reg <= '0;
      // Mode pin follows the synchronised level while reset is held
      r_reg.direct <= mode_s;
      r_reg.div_high <= cgps_pkg::DIV_RESET[1];
      r_reg.div_low <= cgps_pkg::DIV_RESET[0];
      r_reg.state <= cgps_pkg::CGPS_NORMAL;
      r_reg.ratio <= cgps_pkg::CGPS_X5;
    end else begin
      r_reg <= r_next;
    end
  end

  assign DAT_O = {24'h000000, r_reg.rdata};
  assign ACK_O = r_reg.ack;
  assign OSC_EN = r_reg.osc_en;
  assign PLL_EN = r_reg.pll_en;
  assign CPU_CLK_EN = r_reg.cpu_en;
  assign PERI_CLK_EN = r_reg.peri_en;
  assign SYSTEM_CLOCK_OUTPUT_EN = r_reg.clk_out_en;
  assign CLK_RATIO = r_reg.ratio;
  assign PLL_LOCK = r_reg.lock;
  assign DIRECT_MODE = r_reg.direct;

  // Checks
  mode_held_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    RST_B && $past(RST_B) |-> r_reg.direct == $past(r_reg.direct))
    else $error("mode changed outside reset");
  direct_ratio_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    r_reg.direct && $past(RST_B) |-> r_reg.ratio == cgps_pkg::CGPS_HALF &&
    !r_reg.pll_en && !r_reg.osc_en)
    else $error("direct mode clocking wrong");
  unprot_err_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    wr && !r_reg.armed && ADR_I == cgps_pkg::OFF_PWR |=>
    r_reg.err && $stable(r_reg.stop_bit) && $stable(r_reg.idle_bit))
    else $error("unprotected write not refused");
  // Enables are registered with the state, so they match it in every cycle but the first after reset
  stop_clocks_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    r_reg.state == cgps_pkg::CGPS_STOP |->
    !r_reg.pll_en && !r_reg.osc_en && !r_reg.peri_en)
    else $error("clocks running in stop");
  stop_prio_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    r_reg.state == cgps_pkg::CGPS_NORMAL && r_reg.stop_bit |=>
    r_reg.state == cgps_pkg::CGPS_STOP)
    else $error("stop request not taken");
  stop_clear_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    r_reg.state == cgps_pkg::CGPS_STOP && nmi_s |=>
    !r_reg.stop_bit ##0 r_reg.state != cgps_pkg::CGPS_STOP)
    else $error("stop bit not cleared on release");
  idle_exit_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    r_reg.state == cgps_pkg::CGPS_IDLE && !nmi_s |=>
    r_reg.state == cgps_pkg::CGPS_IDLE)
    else $error("idle left without nmi");
  halt_clk_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    r_reg.state == cgps_pkg::CGPS_HALT && !(nmi_s | int_s) |=>
    r_reg.peri_en && !r_reg.cpu_en)
    else $error("halt clock gating wrong");
  inhibit_out_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    r_reg.inhibit |-> !r_reg.clk_out_en)
    else $error("clock out while inhibited");
  stab_wait_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    $rose(r_reg.state == cgps_pkg::CGPS_STAB) |->
    !r_reg.cpu_en [*2])
    else $error("clock used during stabilisation");
endmodule
`default_nettype wire

// File: tb/cgps_clk_src.sv
// Input clock source model: a resonator or a driven clock.
// Assumes the bench says which is fitted and when it fails.
`timescale 1ns/1ps
`default_nettype none
module cgps_clk_src #(
  parameter int START_CYC = 3
) (
  input wire logic clk,
  input wire logic run,
  input wire logic ext,
  input wire logic osc_en,
  output logic present
);
  logic [7:0] cnt_reg;
  // A resonator swings only with its amplifier on, after a start-up
  always_ff @(posedge clk) begin
    if (!run || (!ext && !osc_en)) begin
      cnt_reg <= 8'h00;
    end else if (cnt_reg < 8'(START_CYC)) begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end
  // A driven clock needs no amplifier
  assign present = run && (ext || cnt_reg >= 8'(START_CYC));
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// Self-checking bench for the clock generator and power save block.
// Assumes shortened lock, stabilisation and loss counts.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic mode_pin = 1'b0;
  logic run = 1'b1;
  logic ext = 1'b0;
  logic nmi = 1'b0;
  logic irq = 1'b0;
  logic halt = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] dat = 32'h0;
  logic [31:0] rdat;
  logic ack, osc, pll, cpu, peri, cko, lock, direct, present;
  logic [1:0] ratio;
  logic [7:0] q;
  int n_fail = 0;
  int n_checks = 0;
  wire logic [7:0] st = {ratio == 2'h3, direct, lock, cko, peri, cpu, pll,
    osc};

  always #25 clk_sys = ~clk_sys;

  cgps_top #(.LOCK_CYCLES(20), .STAB_CYCLES(10), .LOSS_CYCLES(4))
    cgps_top_inst (.CLK_SYS(clk_sys), .RST_B(rst_b),
    .CLOCK_MODE_SELECT_PIN(mode_pin), .INPUT_CLK_PRESENT(present),
    .NMI_IN(nmi), .INT_REQ(irq), .HALT_REQ(halt), .CYC_I(cyc), .STB_I(stb),
    .WE_I(we), .ADR_I(adr), .SEL_I(4'h1), .DAT_I(dat), .DAT_O(rdat),
    .ACK_O(ack), .OSC_EN(osc), .PLL_EN(pll), .CPU_CLK_EN(cpu),
    .PERI_CLK_EN(peri), .SYSTEM_CLOCK_OUTPUT_EN(cko), .CLK_RATIO(ratio),
    .PLL_LOCK(lock), .DIRECT_MODE(direct));

  cgps_clk_src cgps_clk_src_inst (.clk(clk_sys), .run(run), .ext(ext),
    .osc_en(osc), .present(present));

  task automatic wrap_up();
    $display("checks=%0d errors=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s,
      input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] %s exp=%0h got=%0h", nm, e, s);
    end
  endtask

  // Bounded wait for one watched output to reach a level
  task automatic wt(input int b, input logic v);
    int i;
    for (i = 0; i < 300 && st[b] !== v; i++)
      @(posedge clk_sys);
    if (st[b] !== v) begin
      n_fail++;
      $display("[ERR] wait bit %0d exp=%0b", b, v);
      wrap_up();
    end
  endtask

  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    int i;
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h0, d};
    i = 0;
    do begin
      @(posedge clk_sys);
      i++;
    end while (ack !== 1'b1 && i < 20);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (ack !== 1'b1) begin
      n_fail++;
      $display("[ERR] bus ack exp=1 got=0");
      wrap_up();
    end
  endtask

  task automatic pw(input logic [3:0] a, input logic [7:0] d);
    wb(1'b1, cgps_pkg::OFF_KEY, cgps_pkg::KEY_VALUE);
    wb(1'b1, a, d);
  endtask

  task automatic rd(input string nm, input logic [3:0] a,
      input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    chk(nm, q, e);
  endtask

  task automatic rst(input logic pin);
    @(posedge clk_sys);
    rst_b <= 1'b0;
    mode_pin <= pin;
    ext <= pin;
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk_sys);
  endtask

  task automatic t_reset_pll();
    rst(1'b0);
    chk("direct", direct, 0);
    chk("ratio", ratio, 0);
    chk("osc", osc, 1);
    chk("pll", pll, 1);
    chk("lock", lock, 0);
    wt(5, 1'b1);
    rd("status", cgps_pkg::OFF_STAT, 8'h01);
    rd("unmapped", 4'h2, 8'h00);
  endtask

  task automatic t_prot();
    wb(1'b1, cgps_pkg::OFF_DIV, 8'h02);
    rd("div", cgps_pkg::OFF_DIV, 8'h00);
    rd("err", cgps_pkg::OFF_STAT, 8'h11);
    wb(1'b1, cgps_pkg::OFF_STAT, 8'h10);
    rd("errclr", cgps_pkg::OFF_STAT, 8'h01);
    wb(1'b1, cgps_pkg::OFF_KEY, cgps_pkg::KEY_VALUE);
    wb(1'b1, 4'h2, 8'h00);
    wb(1'b1, cgps_pkg::OFF_PWR, 8'h04);
    rd("pwr", cgps_pkg::OFF_PWR, 8'h00);
    chk("peri", peri, 1);
    wb(1'b1, cgps_pkg::OFF_STAT, 8'h10);
  endtask

  task automatic t_div();
    logic [7:0] dv [3] = '{8'h02, 8'h03, 8'h00};
    logic [1:0] rt [3] = '{2'h1, 2'h2, 2'h0};
    for (int k = 0; k < 3; k++) begin
      pw(cgps_pkg::OFF_DIV, dv[k]);
      rd("div", cgps_pkg::OFF_DIV, dv[k]);
      chk("ratio", ratio, rt[k]);
    end
    pw(cgps_pkg::OFF_DIV, 8'h01);
    rd("divbad", cgps_pkg::OFF_DIV, 8'h00);
    wb(1'b0, cgps_pkg::OFF_STAT, 8'h00);
    chk("errbad", q[4], 1);
    wb(1'b1, cgps_pkg::OFF_STAT, 8'h10);
    wt(5, 1'b1);
  endtask

  task automatic t_inhibit();
    pw(cgps_pkg::OFF_PWR, 8'h01);
    wt(4, 1'b0);
    chk("cpu", cpu, 1);
    pw(cgps_pkg::OFF_PWR, 8'h00);
    wt(4, 1'b1);
    // Driven input clock, so the amplifier may be switched off
    ext <= 1'b1;
    pw(cgps_pkg::OFF_PWR, 8'h08);
    wt(0, 1'b0);
    chk("pll", pll, 1);
    rd("pwr", cgps_pkg::OFF_PWR, 8'h08);
    pw(cgps_pkg::OFF_PWR, 8'h00);
    wt(0, 1'b1);
    repeat (4) @(posedge clk_sys);
    ext <= 1'b0;
  endtask

  task automatic t_halt();
    @(posedge clk_sys);
    halt <= 1'b1;
    @(posedge clk_sys);
    halt <= 1'b0;
    wt(2, 1'b0);
    chk("peri", peri, 1);
    chk("oscpll", {osc, pll}, 2'h3);
    irq <= 1'b1;
    wt(2, 1'b1);
    irq <= 1'b0;
  endtask

  task automatic t_idle();
    pw(cgps_pkg::OFF_PWR, 8'h04);
    wt(3, 1'b0);
    chk("cpu", cpu, 0);
    chk("oscpll", {osc, pll, lock}, 3'h7);
    irq <= 1'b1;
    repeat (8) @(posedge clk_sys);
    chk("idle", peri, 0);
    irq <= 1'b0;
    nmi <= 1'b1;
    wt(3, 1'b1);
    nmi <= 1'b0;
    chk("lock", lock, 1);
    rd("pwr", cgps_pkg::OFF_PWR, 8'h00);
  endtask

  task automatic t_stop();
    int n;
    pw(cgps_pkg::OFF_PWR, 8'h06);
    wt(1, 1'b0);
    chk("osc", osc, 0);
    chk("clk", {cpu, peri}, 2'h0);
    nmi <= 1'b1;
    wt(0, 1'b1);
    nmi <= 1'b0;
    for (n = 0; n < 100 && cpu !== 1'b1; n++)
      @(posedge clk_sys);
    // Ten stabilisation cycles, as set on the instance; a hang gives 100
    chk("stab", n, 10);
    rd("pwr", cgps_pkg::OFF_PWR, 8'h00);
    wt(5, 1'b1);
  endtask

  task automatic t_loss();
    run <= 1'b0;
    wt(7, 1'b1);
    chk("cpu", cpu, 1);
    run <= 1'b1;
    wt(7, 1'b0);
    chk("ratio", ratio, 0);
  endtask

  task automatic t_direct();
    rst(1'b1);
    chk("direct", direct, 1);
    chk("ratio", ratio, 2);
    chk("oscpll", {osc, pll}, 2'h0);
    // Status register reports direct mode in bit 7 while direct mode runs
    wb(1'b0, cgps_pkg::OFF_STAT, 8'h00);
    chk("stdir", q[7], 1);
  endtask

  initial begin
    t_reset_pll();
    t_prot();
    t_div();
    t_inhibit();
    t_halt();
    t_idle();
    t_stop();
    t_loss();
    t_direct();
    wrap_up();
  end
endmodule
`default_nettype wire
